/* File: verilog/swc_map.svh */
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// register offsets on the plain register port
`define SWC_OFF_CTRL    4'h0
`define SWC_OFF_MASK    4'h4
`define SWC_OFF_STATUS  4'h8

// system_control_reg field positions
`define SWC_BIT_SLEEP_EXIT 1
`define SWC_BIT_DEEP       2
`define SWC_BIT_WAKE_PEND  4

// mask register field positions
`define SWC_BIT_INT_MASK   0
`define SWC_BIT_FAULT_MASK 1

// status register field positions
`define SWC_BIT_ST_SLEEP   0
`define SWC_BIT_ST_DEEP    1
`define SWC_BIT_ST_EVT     2
`define SWC_BIT_ST_ENTRY   3

// reset and idle values
`define SWC_ZERO_WORD 32'h0000_0000

`endif

/* File: verilog/swc_pkg.sv */
package swc_pkg;

  // power state, gray coded along run, sleep, wake
  typedef enum logic [1:0] {
    SWC_RUN   = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_WAKE  = 2'b11
  } swc_state_t;

  // which instruction put the core to sleep
  typedef enum logic {
    SWC_KIND_INT = 1'b0,
    SWC_KIND_EVT = 1'b1
  } swc_kind_t;

endpackage : swc_pkg

/* File: verilog/swc_prio_if.sv */
`timescale 1ns/1ps
interface swc_prio_if #(
  parameter int PRIO_W = 3
);
  logic              pendValid;   // an exception is pending
  logic              pendEnabled; // pending exception is enabled
  logic              pendNmi;     // pending exception is non-maskable
  logic [PRIO_W-1:0] pendPrio;    // its priority, lower is higher
  logic [PRIO_W-1:0] execPrio;    // current execution priority
  logic              intMask;     // interrupt_mask_bit
  logic              fault_mask_bit;   // fault_mask_bit
  logic              wakeOk;      // strong enough to wake
  logic              entryOk;     // strong enough to enter handler

  modport eval (
    input  pendValid, pendEnabled, pendNmi, pendPrio, execPrio, intMask, fault_mask_bit,
    output wakeOk, entryOk
  );
  modport ctrl (
    output pendValid, pendEnabled, pendNmi, pendPrio, execPrio, intMask, fault_mask_bit,
    input  wakeOk, entryOk
  );
endinterface : swc_prio_if

/* File: verilog/swc_wake_eval.sv */
`timescale 1ns/1ps
module swc_wake_eval (
  swc_prio_if.eval prio
);

  logic prioOk; // enabled and above current level

  // priority compare and mask gating
  always_comb begin
    prioOk = prio.pendValid && prio.pendEnabled && (prio.pendPrio < prio.execPrio);
    // interrupt mask does not block waking, fault mask does
    prio.wakeOk = prio.pendNmi || (prioOk && !prio.fault_mask_bit);
    // handler entry waits for both masks to be clear, a non-maskable one enters at once
    prio.entryOk = prio.pendNmi || (prioOk && !prio.fault_mask_bit && !prio.intMask);
  end

endmodule : swc_wake_eval

/* File: verilog/sleep_wake_control.sv */
`timescale 1ns/1ps
`include "swc_map.svh"
module sleep_wake_control #(
  parameter int ADDR_W = 4,
  parameter int PRIO_W = 3
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata,
  input  wire logic              waitIntExec,
  input  wire logic              waitEvtExec,
  input  wire logic              sendEvtExec,
  input  wire logic              handlerReturn,
  input  wire logic              newPending,
  input  wire logic              extEvent,
  input  wire logic              debugWake,
  input  wire logic              pendValid,
  input  wire logic              pendEnabled,
  input  wire logic              pendNmi,
  input  wire logic [PRIO_W-1:0] pendPrio,
  input  wire logic [PRIO_W-1:0] execPrio,
  output logic                   coreHalt,
  output logic                   procClkEn,
  output logic                   sysClkEn,
  output logic                   pllEn,
  output logic                   flashEn,
  output logic                   entryAllowed
);

  // software visible control bits
  logic sleepOnExit;        // sleep_on_exit_bit
  logic deepSel;            // deep_sleep_select_bit
  logic wakeOnPend;         // wake_on_pending_bit
  logic intMask;            // interrupt_mask_bit
  logic fault_mask_bit;          // fault_mask_bit
  logic next_sleepOnExit;   // next control values
  logic next_deepSel;
  logic next_wakeOnPend;
  logic next_intMask;
  logic next_fault_mask_bit;
  logic [31:0] next_regRdata; // read data for next cycle

  // power state
  swc_pkg::swc_state_t state;      // current power state
  swc_pkg::swc_state_t next_state; // next power state
  swc_pkg::swc_kind_t  kind;       // cause of the current sleep
  swc_pkg::swc_kind_t  next_kind;
  logic deepMode;                  // deep sleep chosen at entry
  logic next_deepMode;
  logic eventLatch;                // hidden one-bit event latch
  logic next_eventLatch;
  logic next_coreHalt;             // registered output values
  logic next_procClkEn;
  logic next_sysClkEn;
  logic next_pllEn;
  logic next_flashEn;
  logic next_entryAllowed;

  // derived conditions
  logic setEvent;    // any source raising the event latch
  logic sleepWanted; // a sleep request taken this cycle
  logic wakeNow;     // wake condition for the present sleep

  swc_prio_if #(.PRIO_W(PRIO_W)) prio ();

  // feed the priority evaluator
  assign prio.pendValid   = pendValid;
  assign prio.pendEnabled = pendEnabled;
  assign prio.pendNmi     = pendNmi;
  assign prio.pendPrio    = pendPrio;
  assign prio.execPrio    = execPrio;
  assign prio.intMask     = intMask;
  assign prio.fault_mask_bit   = fault_mask_bit;

  swc_wake_eval u_eval (
    .prio (prio.eval)
  );

  // register writes and read mux; the event latch is never decoded
  always_comb begin
    next_sleepOnExit = sleepOnExit;
    next_deepSel     = deepSel;
    next_wakeOnPend  = wakeOnPend;
    next_intMask     = intMask;
    next_fault_mask_bit   = fault_mask_bit;
    next_regRdata    = `SWC_ZERO_WORD;
    if (regWrite) begin
      case (regAddr)
        `SWC_OFF_CTRL: begin
          next_sleepOnExit = regWdata[`SWC_BIT_SLEEP_EXIT];
          next_deepSel     = regWdata[`SWC_BIT_DEEP];
          next_wakeOnPend  = regWdata[`SWC_BIT_WAKE_PEND];
        end
        `SWC_OFF_MASK: begin
          next_intMask   = regWdata[`SWC_BIT_INT_MASK];
          next_fault_mask_bit = regWdata[`SWC_BIT_FAULT_MASK];
        end
        // status and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `SWC_OFF_CTRL: begin
          next_regRdata[`SWC_BIT_SLEEP_EXIT] = sleepOnExit;
          next_regRdata[`SWC_BIT_DEEP]       = deepSel;
          next_regRdata[`SWC_BIT_WAKE_PEND]  = wakeOnPend;
        end
        `SWC_OFF_MASK: begin
          next_regRdata[`SWC_BIT_INT_MASK]   = intMask;
          next_regRdata[`SWC_BIT_FAULT_MASK] = fault_mask_bit;
        end
        `SWC_OFF_STATUS: begin
          next_regRdata[`SWC_BIT_ST_SLEEP] = (state != swc_pkg::SWC_RUN);
          next_regRdata[`SWC_BIT_ST_DEEP]  = deepMode;
          next_regRdata[`SWC_BIT_ST_EVT]   = (kind == swc_pkg::SWC_KIND_EVT);
          next_regRdata[`SWC_BIT_ST_ENTRY] = entryAllowed;
        end
        // unmapped offsets read as zero
        default: begin
        end
      endcase
    end
  end

  // register the software state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleepOnExit <= 1'b0;
      deepSel     <= 1'b0;
      wakeOnPend  <= 1'b0;
      intMask     <= 1'b0;
      fault_mask_bit   <= 1'b0;
      regRdata    <= `SWC_ZERO_WORD;
    end else begin
      sleepOnExit <= next_sleepOnExit;
      deepSel     <= next_deepSel;
      wakeOnPend  <= next_wakeOnPend;
      intMask     <= next_intMask;
      fault_mask_bit   <= next_fault_mask_bit;
      regRdata    <= next_regRdata;
    end
  end

  // power sequencing, event latch and clock gates
  always_comb begin
    next_state      = state;
    next_kind       = kind;
    next_deepMode   = deepMode;
    next_eventLatch = eventLatch;
    sleepWanted     = 1'b0;
    wakeNow         = 1'b0;
    // send event, external event, or new pending with wake-on-pending
    setEvent = (sendEvtExec && state == swc_pkg::SWC_RUN) || extEvent
             || (wakeOnPend && newPending);
    case (state)
      swc_pkg::SWC_RUN: begin
        if (waitIntExec) begin
          // skip the sleep when a waking exception already stands
          if (!prio.wakeOk) begin
            sleepWanted = 1'b1;
            next_kind   = swc_pkg::SWC_KIND_INT;
          end
        end else if (waitEvtExec) begin
          // only the latch value decides
          if (!eventLatch) begin
            sleepWanted = 1'b1;
            next_kind   = swc_pkg::SWC_KIND_EVT;
          end else begin
            next_eventLatch = 1'b0;
          end
        end else if (handlerReturn && sleepOnExit) begin
          // back to thread mode and straight to sleep
          sleepWanted = 1'b1;
          next_kind   = swc_pkg::SWC_KIND_INT;
        end
        if (sleepWanted) begin
          next_state    = swc_pkg::SWC_SLEEP;
          next_deepMode = deepSel;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        if (kind == swc_pkg::SWC_KIND_INT) begin
          wakeNow = prio.wakeOk;
        end else begin
          // exception wake, or an event raised while asleep
          wakeNow = prio.wakeOk || setEvent || eventLatch;
          if (wakeNow) begin
            next_eventLatch = 1'b0;
          end
        end
        // debug and other spurious wakes leave the core running
        if (wakeNow || debugWake) begin
          next_state = swc_pkg::SWC_WAKE;
        end
      end
      swc_pkg::SWC_WAKE: begin
        // clocks restarted, release the core next cycle
        next_state    = swc_pkg::SWC_RUN;
        next_deepMode = 1'b0;
      end
      default: begin
        next_state = swc_pkg::SWC_RUN;
      end
    endcase
    // a set arriving with a clear still wins; only an event-wait wake consumes it
    if (setEvent && !(state == swc_pkg::SWC_SLEEP && wakeNow
                      && kind == swc_pkg::SWC_KIND_EVT)) begin
      next_eventLatch = 1'b1;
    end
    // clock gates follow the next state so they match state
    next_coreHalt  = (next_state != swc_pkg::SWC_RUN);
    next_procClkEn = (next_state != swc_pkg::SWC_SLEEP);
    next_sysClkEn  = !(next_state == swc_pkg::SWC_SLEEP && next_deepMode);
    next_pllEn     = next_sysClkEn;
    next_flashEn   = next_sysClkEn;
    // handler entry held off while masked, even after a wake
    next_entryAllowed = prio.entryOk && (next_state == swc_pkg::SWC_RUN);
  end

  // register power state; event latch cleared by reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state        <= swc_pkg::SWC_RUN;
      kind         <= swc_pkg::SWC_KIND_INT;
      deepMode     <= 1'b0;
      eventLatch   <= 1'b0;
      coreHalt     <= 1'b0;
      procClkEn    <= 1'b1;
      sysClkEn     <= 1'b1;
      pllEn        <= 1'b1;
      flashEn      <= 1'b1;
      entryAllowed <= 1'b0;
    end else begin
      state        <= next_state;
      kind         <= next_kind;
      deepMode     <= next_deepMode;
      eventLatch   <= next_eventLatch;
      coreHalt     <= next_coreHalt;
      procClkEn    <= next_procClkEn;
      sysClkEn     <= next_sysClkEn;
      pllEn        <= next_pllEn;
      flashEn      <= next_flashEn;
      entryAllowed <= next_entryAllowed;
    end
  end

  // interrupt wait with no waking exception halts next cycle
  property p_int_sleep;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && waitIntExec && !prio.wakeOk)
      |=> (state == swc_pkg::SWC_SLEEP && coreHalt && !procClkEn);
  endproperty
  a_int_sleep: assert property (p_int_sleep) else $error("no sleep on interrupt wait");

  // interrupt wait with a waking exception keeps running
  property p_int_skip;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && waitIntExec && prio.wakeOk) |=> !coreHalt;
  endproperty
  a_int_skip: assert property (p_int_skip) else $error("slept with wake pending");

  // event wait with latch clear sleeps
  property p_evt_sleep;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && !waitIntExec && waitEvtExec && !eventLatch)
      |=> (state == swc_pkg::SWC_SLEEP && kind == swc_pkg::SWC_KIND_EVT);
  endproperty
  a_evt_sleep: assert property (p_evt_sleep) else $error("no sleep on event wait");

  // event wait with latch set consumes it and runs on
  property p_evt_skip;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && !waitIntExec && waitEvtExec && eventLatch && !setEvent)
      |=> (!eventLatch && !coreHalt);
  endproperty
  a_evt_skip: assert property (p_evt_skip) else $error("event not consumed");

  // send event makes the next event wait fall through
  property p_send_set;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && sendEvtExec) |=> eventLatch;
  endproperty
  a_send_set: assert property (p_send_set) else $error("send event lost");

  // handler return with sleep on exit sleeps at once
  property p_exit_sleep;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_RUN && !waitIntExec && !waitEvtExec
       && handlerReturn && sleepOnExit) |=> coreHalt;
  endproperty
  a_exit_sleep: assert property (p_exit_sleep) else $error("no sleep on exit");

  // interrupt-wait sleep holds without a waking exception
  property p_int_hold;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && kind == swc_pkg::SWC_KIND_INT
       && !prio.wakeOk && !debugWake) |=> (state == swc_pkg::SWC_SLEEP);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("sleep woke without cause");

  // masked interrupt never admits a handler
  property p_mask_hold;
    @(posedge clock) disable iff (!rst_n)
      (intMask && !pendNmi) |=> !entryAllowed;
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("handler entered while masked");

  // event-wait sleep wakes then runs two cycles later
  property p_evt_wake;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && kind == swc_pkg::SWC_KIND_EVT && prio.wakeOk)
      |=> (state == swc_pkg::SWC_WAKE) ##1 !coreHalt;
  endproperty
  a_evt_wake: assert property (p_evt_wake) else $error("event sleep not woken");

  // new pending interrupt wakes event-wait sleep
  property p_pend_wake;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && kind == swc_pkg::SWC_KIND_EVT
       && wakeOnPend && newPending) |=> (state == swc_pkg::SWC_WAKE);
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("pending event did not wake");

  // debug wake returns to run within two cycles
  property p_spurious;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && debugWake) |-> ##[1:2] !coreHalt;
  endproperty
  a_spurious: assert property (p_spurious) else $error("spurious wake stuck");

  // ordinary sleep keeps system clocks alive
  property p_light_clocks;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && !deepMode) |-> (!procClkEn && sysClkEn && pllEn);
  endproperty
  a_light_clocks: assert property (p_light_clocks) else $error("light sleep clocks wrong");

  // deep sleep turns off system clock, pll and flash
  property p_deep_clocks;
    @(posedge clock) disable iff (!rst_n)
      (state == swc_pkg::SWC_SLEEP && deepMode) |-> (!sysClkEn && !pllEn && !flashEn);
  endproperty
  a_deep_clocks: assert property (p_deep_clocks) else $error("deep sleep clocks on");

  // main scenarios
  c_int_cycle: cover property (@(posedge clock) disable iff (!rst_n)
    (state == swc_pkg::SWC_SLEEP && kind == swc_pkg::SWC_KIND_INT) ##1
    (state == swc_pkg::SWC_WAKE));
  c_evt_skip: cover property (@(posedge clock) disable iff (!rst_n)
    (state == swc_pkg::SWC_RUN && waitEvtExec && eventLatch));
  c_exit_sleep: cover property (@(posedge clock) disable iff (!rst_n)
    (handlerReturn && sleepOnExit) ##1 coreHalt);
  c_deep: cover property (@(posedge clock) disable iff (!rst_n)
    (state == swc_pkg::SWC_SLEEP && deepMode));

endmodule : sleep_wake_control

/* File: tb/swc_core_model.sv */
`timescale 1ns/1ps
// pipeline and interrupt controller stand-in
module swc_core_model (
  input  wire logic       clock,
  input  wire logic       coreHalt,
  output logic      [6:0] pulse,       // int-wait evt-wait send ret pend ext dbg
  output logic            pendValid,   // exception pending
  output logic            pendEnabled, // pending one enabled
  output logic            pendNmi,     // pending one non-maskable
  output logic      [2:0] pendPrio,    // lower is higher
  output logic      [2:0] execPrio     // current level
);
  // quiet at time zero
  initial begin
    pulse       = 7'h00;
    pendValid   = 1'h0;
    pendEnabled = 1'h0;
    pendNmi     = 1'h0;
    pendPrio    = 3'h7;
    execPrio    = 3'h7;
  end

  // one-cycle pulse; a halted pipeline issues no instruction
  task automatic issue(input int idx);
    @(posedge clock);
    while (idx < 4 && coreHalt === 1'h1) begin
      @(posedge clock);
    end
    pulse[idx] <= 1'h1;
    @(posedge clock);
    pulse[idx] <= 1'h0;
  endtask : issue

  // pending exception levels, held until changed
  task automatic setPend(input logic v, input logic en, input logic nmi, input logic [2:0] p);
    @(posedge clock);
    pendValid   <= v;
    pendEnabled <= en;
    pendNmi     <= nmi;
    pendPrio    <= p;
  endtask : setPend
endmodule : swc_core_model

/* File: tb/tb_sleep_wake_control.sv */
`timescale 1ns/1ps
`include "swc_map.svh"
// self-checking bench for sleep and wake control
module tb_sleep_wake_control;
  logic        clock;
  logic        rst_n;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [6:0]  pulse;        // instruction and event pulses
  logic        pendValid;
  logic        pendEnabled;
  logic        pendNmi;
  logic [2:0]  pendPrio;
  logic [2:0]  execPrio;
  logic        coreHalt;
  logic        procClkEn;
  logic        sysClkEn;
  logic        pllEn;
  logic        flashEn;
  logic        entryAllowed;
  logic [31:0] rdat;         // last read word
  int          nMismatch = 0;
  int          checksDone = 0;
  int          cycles = 0;   // hang guard
  localparam int I_WINT = 0, I_WEVT = 1, I_SEND = 2, I_RET = 3, I_PEND = 4, I_EXT = 5, I_DBG = 6;

  sleep_wake_control dut (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .waitIntExec(pulse[0]), .waitEvtExec(pulse[1]), .sendEvtExec(pulse[2]),
    .handlerReturn(pulse[3]),
    .newPending(pulse[4]), .extEvent(pulse[5]), .debugWake(pulse[6]),
    .pendValid(pendValid), .pendEnabled(pendEnabled), .pendNmi(pendNmi),
    .pendPrio(pendPrio), .execPrio(execPrio), .coreHalt(coreHalt), .procClkEn(procClkEn),
    .sysClkEn(sysClkEn), .pllEn(pllEn), .flashEn(flashEn), .entryAllowed(entryAllowed)
  );

  swc_core_model core (
    .clock(clock), .coreHalt(coreHalt), .pulse(pulse), .pendValid(pendValid),
    .pendEnabled(pendEnabled), .pendNmi(pendNmi), .pendPrio(pendPrio), .execPrio(execPrio)
  );

  // 25 MHz clock
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // verdict and end of run
  task automatic final_report();
    if (nMismatch == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask : wr

  // one-cycle read, data taken the cycle after
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clock);
    regRead <= 1'h0;
    #1;
    rdat = regRdata;
  endtask : rd

  task automatic halted(input logic h);
    #1;
    check(coreHalt, h);
  endtask : halted

  // bounded wait for the core to run again
  task automatic waitRun();
    int n;
    n = 0;
    #1;
    while (coreHalt !== 1'h0 && n < 6) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(coreHalt, 1'h0);
  endtask : waitRun

  task automatic t_reset();
    #1;
    check({coreHalt, entryAllowed}, 2'h0);
    check({procClkEn, sysClkEn, pllEn, flashEn}, 4'hf);
    rd(`SWC_OFF_STATUS);
    check(rdat, 32'h0000_0000);
  endtask : t_reset

  // event sleep, consumed event, spurious wake and sleep again
  task automatic t_wait_evt();
    core.issue(I_WEVT);
    halted(1'h1);
    check({procClkEn, sysClkEn, pllEn}, 3'h3);
    rd(`SWC_OFF_STATUS);
    check(rdat, 32'h0000_0005);
    core.issue(I_EXT);
    waitRun();
    core.issue(I_WEVT);
    halted(1'h1);
    core.issue(I_DBG);
    waitRun();
    core.issue(I_WEVT);
    halted(1'h1);
    core.issue(I_EXT);
    waitRun();
  endtask : t_wait_evt

  task automatic t_send_evt();
    core.issue(I_SEND);
    core.issue(I_WEVT);
    halted(1'h0);
    core.issue(I_WEVT);
    halted(1'h1);
    core.issue(I_EXT);
    waitRun();
  endtask : t_send_evt

  // pending wake only while enabled
  task automatic t_pend();
    wr(`SWC_OFF_CTRL, 32'h0000_0010);
    core.issue(I_WEVT);
    core.issue(I_PEND);
    waitRun();
    wr(`SWC_OFF_CTRL, 32'h0000_0000);
    core.issue(I_WEVT);
    core.issue(I_PEND);
    repeat (3) @(posedge clock);
    halted(1'h1);
    core.issue(I_EXT);
    waitRun();
  endtask : t_pend

  // interrupt wait; an event raised while asleep survives the wake
  task automatic t_wait_int();
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    core.issue(I_WINT);
    halted(1'h0);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h7);
    core.issue(I_WINT);
    core.issue(I_EXT);
    repeat (2) @(posedge clock);
    halted(1'h1);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    waitRun();
    check(entryAllowed, 1'h1);
    core.issue(I_WEVT);
    halted(1'h0);
    core.setPend(1'h1, 1'h0, 1'h0, 3'h2);
    core.issue(I_WEVT);
    halted(1'h1);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    waitRun();
    core.setPend(1'h0, 1'h0, 1'h0, 3'h7);
  endtask : t_wait_int

  // interrupt mask delays entry, fault mask leaves only nmi
  task automatic t_mask();
    wr(`SWC_OFF_MASK, 32'h0000_0001);
    core.issue(I_WINT);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    waitRun();
    check(entryAllowed, 1'h0);
    rd(`SWC_OFF_STATUS);
    check(rdat, 32'h0000_0000);
    wr(`SWC_OFF_MASK, 32'h0000_0000);
    repeat (3) @(posedge clock);
    #1;
    check(entryAllowed, 1'h1);
    core.setPend(1'h0, 1'h0, 1'h0, 3'h7);
    wr(`SWC_OFF_MASK, 32'h0000_0002);
    core.issue(I_WINT);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    repeat (3) @(posedge clock);
    halted(1'h1);
    core.setPend(1'h1, 1'h0, 1'h1, 3'h2);
    waitRun();
    wr(`SWC_OFF_MASK, 32'h0000_0000);
    core.setPend(1'h0, 1'h0, 1'h0, 3'h7);
  endtask : t_mask

  task automatic t_deep();
    wr(`SWC_OFF_CTRL, 32'h0000_0004);
    core.issue(I_WINT);
    #1;
    check({procClkEn, sysClkEn, pllEn, flashEn}, 4'h0);
    rd(`SWC_OFF_STATUS);
    check(rdat, 32'h0000_0003);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    waitRun();
    check({procClkEn, sysClkEn, pllEn, flashEn}, 4'hf);
    wr(`SWC_OFF_CTRL, 32'h0000_0000);
    core.setPend(1'h0, 1'h0, 1'h0, 3'h7);
  endtask : t_deep

  task automatic t_exit();
    wr(`SWC_OFF_CTRL, 32'h0000_0002);
    core.issue(I_RET);
    halted(1'h1);
    core.setPend(1'h1, 1'h1, 1'h0, 3'h2);
    waitRun();
    core.setPend(1'h0, 1'h0, 1'h0, 3'h7);
    wr(`SWC_OFF_CTRL, 32'h0000_0000);
    core.issue(I_RET);
    halted(1'h0);
  endtask : t_exit

  // readback, read-only status, unmapped space
  task automatic t_regs();
    wr(`SWC_OFF_CTRL, 32'h0000_0016);
    rd(`SWC_OFF_CTRL);
    check(rdat, 32'h0000_0016);
    wr(`SWC_OFF_MASK, 32'h0000_0003);
    rd(`SWC_OFF_MASK);
    check(rdat, 32'h0000_0003);
    wr(`SWC_OFF_STATUS, 32'hffff_ffff);
    rd(`SWC_OFF_STATUS);
    check(rdat, 32'h0000_0000);
    rd(4'hc);
    check(rdat, 32'h0000_0000);
  endtask : t_regs

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      final_report();
    end
  end

  // main sequence
  initial begin
    rst_n    = 1'h0;
    regAddr  = 4'h0;
    regWdata = 32'h0000_0000;
    regWrite = 1'h0;
    regRead  = 1'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    t_reset();
    t_wait_evt();
    t_send_evt();
    t_pend();
    t_wait_int();
    t_mask();
    t_deep();
    t_exit();
    t_regs();
    final_report();
  end
endmodule : tb_sleep_wake_control
